// file: rtl/plcr_regs.sv
// Purpose: LED override and PHY control registers with LED output logic
// Assumes: Register port driven by the serial management front end
// Notes:   Straps are taken on the first clock after reset release
`timescale 1ns/1ps
module plcr_regs #(
    parameter int BLINK_CYCLES = plcr_pkg::BLINK_CYCLES
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // Register port
    input  wire logic [4:0]           mgmtAddr,
    input  wire logic [15:0]          mgmtWrData,
    input  wire logic                 mgmtWrEn,
    input  wire logic                 mgmtRdEn,
    output logic      [15:0]          mgmtRdData,
    output logic                      mgmtRdValid,
    // Straps
    input  wire logic                 strapAutoCrossover,
    input  wire logic                 strapLedModeLo,
    input  wire logic [4:0]           strapPortAddr,
    // Status from the PHY core
    input  wire plcr_pkg::plcr_status_t phyStatus,
    input  wire logic [1:0]           localAdvPause,
    input  wire logic [1:0]           partnerAdvPause,
    input  wire logic                 autoSwapRequest,
    input  wire logic                 selftestRxBit,
    // Outputs
    output logic                      speedLedOut,
    output logic                      linkLedOut,
    output logic                      activityCollisionLedOut,
    output logic                      autoCrossoverEn,
    output logic                      pairSwap,
    output logic [4:0]                portAddress,
    output logic                      selftestTxBit
);
    typedef struct packed {
        plcr_pkg::plcr_led_ovr_t ovr;
        plcr_pkg::plcr_misc_t    misc;
        logic                    strapsTaken;
        logic [15:0]             rdData;
        logic                    rdValid;
        logic [plcr_pkg::BLINK_W-1:0] blinkCnt;
        logic                    blinkPhase;
        logic                    speed_led_force_value;
        logic                    link_led_force_value;
        logic                    activity_led_force_value;
        logic                    autoX;
        logic                    swap;
        logic [4:0]              addr;
    } plcr_top_t;

    localparam logic [plcr_pkg::BLINK_W-1:0] BLINK_LAST =
        plcr_pkg::BLINK_W'(BLINK_CYCLES - 1);

    plcr_top_t              s_r;
    plcr_top_t              s_nxt;
    logic                   pauseRx;
    logic                   pauseTx;
    logic                   passFlag;
    logic                   stTx;
    plcr_pkg::plcr_led_mode_t mode;
    logic                   act;
    logic                   col;
    logic                   lnk;
    logic                   ac;
    logic [15:0]            ovrWord;
    logic [15:0]            miscWord;

    plcr_pause_resolve u_pause (
        .localAdv   (localAdvPause),
        .partnerAdv (partnerAdvPause),
        .fullDuplex (phyStatus.fullDuplex),
        .pauseRx    (pauseRx),
        .pauseTx    (pauseTx)
    );

    plcr_selftest u_selftest (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .run       (s_r.misc.run),
        .seqSelect (s_r.misc.seqSelect),
        .forceErr  (s_r.misc.forceErr),
        .rxBit     (selftestRxBit),
        .txBit     (stTx),
        .passFlag  (passFlag)
    );

    always_comb begin
        ovrWord = 16'h0000;
        ovrWord[plcr_pkg::SPD_OVR_EN_BIT] = s_r.ovr.spdOvrEn;
        ovrWord[plcr_pkg::LNK_OVR_EN_BIT] = s_r.ovr.lnkOvrEn;
        ovrWord[plcr_pkg::ACT_OVR_EN_BIT] = s_r.ovr.actOvrEn;
        ovrWord[plcr_pkg::SPD_FORCE_BIT]  = s_r.ovr.spdForce;
        ovrWord[plcr_pkg::LNK_FORCE_BIT]  = s_r.ovr.lnkForce;
        ovrWord[plcr_pkg::ACT_FORCE_BIT]  = s_r.ovr.actForce;

        miscWord = 16'h0000;
        miscWord[plcr_pkg::AUTO_X_BIT]   = s_r.misc.autoCrossoverEn;
        miscWord[plcr_pkg::FORCE_X_BIT]  = s_r.misc.forcedCrossover;
        miscWord[plcr_pkg::PAUSE_RX_BIT] = pauseRx;
        miscWord[plcr_pkg::PAUSE_TX_BIT] = pauseTx;
        miscWord[plcr_pkg::ST_FE_BIT]    = s_r.misc.forceErr;
        miscWord[plcr_pkg::ST_SEQ_BIT]   = s_r.misc.seqSelect;
        miscWord[plcr_pkg::ST_PASS_BIT]  = passFlag;
        miscWord[plcr_pkg::ST_RUN_BIT]   = s_r.misc.run;
        miscWord[plcr_pkg::BYPASS_BIT]   = s_r.misc.stretchBypass;
        miscWord[plcr_pkg::MODE_HI_BIT:plcr_pkg::MODE_LO_BIT] = s_r.misc.ledMode;
        miscWord[plcr_pkg::ADDR_LSB +: plcr_pkg::ADDR_W]      = s_r.misc.portAddr;
    end

    always_comb begin
        s_nxt = s_r;

        // Straps loaded once, just after reset release
        if (!s_r.strapsTaken) begin
            s_nxt.strapsTaken           = 1'b1;
            s_nxt.misc.autoCrossoverEn  = strapAutoCrossover;
            s_nxt.misc.ledMode[0]       = strapLedModeLo;
            s_nxt.misc.portAddr         = strapPortAddr;
        end

        // Force error is high for one cycle only
        s_nxt.misc.forceErr = 1'b0;

        if (mgmtWrEn && mgmtAddr == plcr_pkg::ADDR_LED_OVR) begin
            s_nxt.ovr.spdOvrEn = mgmtWrData[plcr_pkg::SPD_OVR_EN_BIT];
            s_nxt.ovr.lnkOvrEn = mgmtWrData[plcr_pkg::LNK_OVR_EN_BIT];
            s_nxt.ovr.actOvrEn = mgmtWrData[plcr_pkg::ACT_OVR_EN_BIT];
            s_nxt.ovr.spdForce = mgmtWrData[plcr_pkg::SPD_FORCE_BIT];
            s_nxt.ovr.lnkForce = mgmtWrData[plcr_pkg::LNK_FORCE_BIT];
            s_nxt.ovr.actForce = mgmtWrData[plcr_pkg::ACT_FORCE_BIT];
        end
        if (mgmtWrEn && mgmtAddr == plcr_pkg::ADDR_MISC) begin
            s_nxt.misc.autoCrossoverEn = mgmtWrData[plcr_pkg::AUTO_X_BIT];
            s_nxt.misc.forcedCrossover = mgmtWrData[plcr_pkg::FORCE_X_BIT];
            s_nxt.misc.forceErr        = mgmtWrData[plcr_pkg::ST_FE_BIT];
            s_nxt.misc.seqSelect       = mgmtWrData[plcr_pkg::ST_SEQ_BIT];
            s_nxt.misc.run             = mgmtWrData[plcr_pkg::ST_RUN_BIT];
            s_nxt.misc.stretchBypass   = mgmtWrData[plcr_pkg::BYPASS_BIT];
            s_nxt.misc.ledMode         =
                mgmtWrData[plcr_pkg::MODE_HI_BIT:plcr_pkg::MODE_LO_BIT];
            s_nxt.misc.portAddr        =
                mgmtWrData[plcr_pkg::ADDR_LSB +: plcr_pkg::ADDR_W];
        end

        // Read answer one cycle after the request
        s_nxt.rdValid = mgmtRdEn;
        s_nxt.rdData  = 16'h0000;
        if (mgmtRdEn) begin
            case (mgmtAddr)
                plcr_pkg::ADDR_LED_OVR: begin
                    s_nxt.rdData = ovrWord;
                end
                plcr_pkg::ADDR_MISC: begin
                    s_nxt.rdData = miscWord;
                end
                default: begin
                    s_nxt.rdData = 16'h0000;
                end
            endcase
        end

        // Blink timebase
        if (s_r.blinkCnt >= BLINK_LAST) begin
            s_nxt.blinkCnt   = '0;
            s_nxt.blinkPhase = !s_r.blinkPhase;
        end else begin
            s_nxt.blinkCnt = s_r.blinkCnt + 1'b1;
        end

        // Stretch bypass picks raw status
        act = s_r.misc.stretchBypass ? phyStatus.activityRaw
                                     : phyStatus.activityStretched;
        col = s_r.misc.stretchBypass ? phyStatus.collisionRaw
                                     : phyStatus.collisionStretched;

        mode = plcr_pkg::plcr_mode_decode(s_r.misc.ledMode);
        case (mode)
            plcr_pkg::PLCR_MODE1: begin
                lnk = phyStatus.linkGood;
                ac  = act;
            end
            plcr_pkg::PLCR_MODE2: begin
                lnk = phyStatus.linkGood && !(act && s_r.blinkPhase);
                ac  = col;
            end
            plcr_pkg::PLCR_MODE3: begin
                lnk = phyStatus.linkGood && !(act && s_r.blinkPhase);
                ac  = phyStatus.fullDuplex;
            end
            default: begin
                lnk = phyStatus.linkGood;
                ac  = act;
            end
        endcase

        s_nxt.speed_led_force_value = s_r.ovr.spdOvrEn ? s_r.ovr.spdForce
                                        : phyStatus.speed100;
        s_nxt.link_led_force_value = s_r.ovr.lnkOvrEn ? s_r.ovr.lnkForce : lnk;
        s_nxt.activity_led_force_value = s_r.ovr.actOvrEn ? s_r.ovr.actForce : ac;

        // Forced swap wins over automatic selection
        s_nxt.autoX = s_r.misc.autoCrossoverEn;
        s_nxt.swap  = s_r.misc.forcedCrossover ||
                      (s_r.misc.autoCrossoverEn && autoSwapRequest);
        s_nxt.addr  = s_r.misc.portAddr;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_r                      <= '0;
            s_r.ovr                  <= plcr_pkg::LED_OVR_RST;
            s_r.misc.forcedCrossover <= plcr_pkg::FORCE_X_RST;
            s_r.misc.seqSelect       <= plcr_pkg::ST_SEQ_RST;
            s_r.misc.ledMode[1]      <= plcr_pkg::MODE_HI_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            selftestTxBit <= 1'b0;
        end else begin
            selftestTxBit <= stTx;
        end
    end

    assign mgmtRdData              = s_r.rdData;
    assign mgmtRdValid             = s_r.rdValid;
    assign speedLedOut             = s_r.speed_led_force_value;
    assign linkLedOut              = s_r.link_led_force_value;
    assign activityCollisionLedOut = s_r.activity_led_force_value;
    assign autoCrossoverEn         = s_r.autoX;
    assign pairSwap                = s_r.swap;
    assign portAddress             = s_r.addr;
endmodule

// file: common/plcr_pkg.sv
// Purpose: Shared constants, types and helpers of the LED and control registers
// Assumes: 16-bit register port, 5-bit register address
// Notes:   LED outputs are active high (1 = LED on)
package plcr_pkg;

    localparam logic [4:0] ADDR_LED_OVR = 5'h18;
    localparam logic [4:0] ADDR_MISC    = 5'h19;

    // led_override_control fields
    localparam int SPD_OVR_EN_BIT = 5;
    localparam int LNK_OVR_EN_BIT = 4;
    localparam int ACT_OVR_EN_BIT = 3;
    localparam int SPD_FORCE_BIT  = 2;
    localparam int LNK_FORCE_BIT  = 1;
    localparam int ACT_FORCE_BIT  = 0;
    localparam logic [5:0] LED_OVR_RST = 6'h00;

    // phy_misc_control fields
    localparam int AUTO_X_BIT   = 15;
    localparam int FORCE_X_BIT  = 14;
    localparam int PAUSE_RX_BIT = 13;
    localparam int PAUSE_TX_BIT = 12;
    localparam int ST_FE_BIT    = 11;
    localparam int ST_SEQ_BIT   = 10;
    localparam int ST_PASS_BIT  = 9;
    localparam int ST_RUN_BIT   = 8;
    localparam int BYPASS_BIT   = 7;
    localparam int MODE_HI_BIT  = 6;
    localparam int MODE_LO_BIT  = 5;
    localparam int ADDR_LSB     = 0;
    localparam int ADDR_W       = 5;
    localparam logic       FORCE_X_RST = 1'b0;
    localparam logic       ST_SEQ_RST  = 1'b0;
    localparam logic       MODE_HI_RST = 1'b0;

    // Link LED blink half period
    localparam int CLK_HZ        = 10_000_000;
    localparam int BLINK_TIME_MS = 50;
    localparam int BLINK_CYCLES  = BLINK_TIME_MS * (CLK_HZ / 1000);
    localparam int BLINK_W       = 20;

    localparam int ST_W = 15;

    typedef enum logic [2:0] {
        PLCR_MODE1 = 3'b001,
        PLCR_MODE2 = 3'b010,
        PLCR_MODE3 = 3'b100
    } plcr_led_mode_t;

    typedef enum logic [1:0] {
        PLCR_ST_IDLE = 2'b01,
        PLCR_ST_RUN  = 2'b10
    } plcr_st_phase_t;

    typedef struct packed {
        logic spdOvrEn;
        logic lnkOvrEn;
        logic actOvrEn;
        logic spdForce;
        logic lnkForce;
        logic actForce;
    } plcr_led_ovr_t;

    typedef struct packed {
        logic        autoCrossoverEn;
        logic        forcedCrossover;
        logic        forceErr;
        logic        seqSelect;
        logic        run;
        logic        stretchBypass;
        logic [1:0]  ledMode;
        logic [4:0]  portAddr;
    } plcr_misc_t;

    typedef struct packed {
        logic linkGood;
        logic speed100;
        logic fullDuplex;
        logic activityRaw;
        logic activityStretched;
        logic collisionRaw;
        logic collisionStretched;
    } plcr_status_t;

    typedef struct packed {
        plcr_st_phase_t    phase;
        logic [ST_W-1:0]   txLfsr;
        logic [ST_W-1:0]   rxShift;
        logic [3:0]        fillCnt;
        logic              failLatched;
        logic              txBit;
    } plcr_st_state_t;

    function automatic plcr_led_mode_t plcr_mode_decode(input logic [1:0] f);
        if (f[0]) begin
            return PLCR_MODE1;
        end else if (f[1]) begin
            return PLCR_MODE3;
        end
        return PLCR_MODE2;
    endfunction

    // x^15+x^14+1 when sel, else x^9+x^5+1
    function automatic logic plcr_prbs_fb(input logic sel, input logic [ST_W-1:0] s);
        return sel ? (s[14] ^ s[13]) : (s[8] ^ s[4]);
    endfunction

endpackage

// file: rtl/plcr_pause_resolve.sv
// Purpose: Pause resolution from local and partner pause advertisement
// Assumes: adv[0] = symmetric pause, adv[1] = asymmetric direction
// Notes:   Result forced off unless the common mode is full duplex
`timescale 1ns/1ps
module plcr_pause_resolve (
    input  wire logic [1:0] localAdv,
    input  wire logic [1:0] partnerAdv,
    input  wire logic       fullDuplex,
    output logic            pauseRx,
    output logic            pauseTx
);
    always_comb begin
        pauseRx = 1'b0;
        pauseTx = 1'b0;
        if (localAdv[0] && partnerAdv[0]) begin
            pauseRx = 1'b1;
            pauseTx = 1'b1;
        end else if (localAdv == 2'h2 && partnerAdv == 2'h3) begin
            pauseTx = 1'b1;
        end else if (localAdv == 2'h3 && partnerAdv == 2'h2) begin
            pauseRx = 1'b1;
        end
        pauseRx = pauseRx & fullDuplex;
        pauseTx = pauseTx & fullDuplex;
    end
endmodule

// file: rtl/plcr_selftest.sv
// Purpose: Packet self-test pattern source and self-synchronising checker
// Assumes: rxBit is the looped-back stream, one bit per clock
// Notes:   Pass flag reads 0 while stopped; stream idles high
`timescale 1ns/1ps
module plcr_selftest (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic run,
    input  wire logic seqSelect,
    input  wire logic forceErr,
    input  wire logic rxBit,
    output logic      txBit,
    output logic      passFlag
);
    plcr_pkg::plcr_st_state_t st_r;
    plcr_pkg::plcr_st_state_t st_nxt;
    logic                     fbTx;
    logic                     fbRx;

    localparam int ST_W_M2 = plcr_pkg::ST_W - 2;

    always_comb begin
        st_nxt = st_r;
        fbTx   = plcr_pkg::plcr_prbs_fb(seqSelect, st_r.txLfsr);
        fbRx   = plcr_pkg::plcr_prbs_fb(seqSelect, st_r.rxShift);
        case (st_r.phase)
            plcr_pkg::PLCR_ST_IDLE: begin
                st_nxt.failLatched = 1'b0;
                st_nxt.fillCnt     = 4'h0;
                // Idle line high, so stale loop bits match the all-ones seed
                st_nxt.txBit       = 1'b1;
                st_nxt.txLfsr      = '1;
                if (run) begin
                    st_nxt.phase = plcr_pkg::PLCR_ST_RUN;
                end
            end
            plcr_pkg::PLCR_ST_RUN: begin
                st_nxt.txLfsr  = {st_r.txLfsr[ST_W_M2:0], fbTx};
                st_nxt.txBit   = fbTx ^ forceErr;
                st_nxt.rxShift = {st_r.rxShift[ST_W_M2:0], rxBit};
                if (st_r.fillCnt != 4'hf) begin
                    st_nxt.fillCnt = st_r.fillCnt + 4'h1;
                end else if (rxBit != fbRx) begin
                    st_nxt.failLatched = 1'b1;
                end
                if (!run) begin
                    st_nxt.phase = plcr_pkg::PLCR_ST_IDLE;
                end
            end
            default: begin
                st_nxt.phase = plcr_pkg::PLCR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r.phase       <= plcr_pkg::PLCR_ST_IDLE;
            st_r.txLfsr      <= '1;
            st_r.rxShift     <= '0;
            st_r.fillCnt     <= 4'h0;
            st_r.failLatched <= 1'b0;
            st_r.txBit       <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign txBit    = st_r.txBit;
    assign passFlag = (st_r.phase == plcr_pkg::PLCR_ST_RUN) && !st_r.failLatched;
endmodule

// file: tb/plcr_regs_monitor.sv
// Purpose: Concurrent checks on register reads, LED overrides and control copies
// Assumes: Sees only ports of plcr_regs; one clock domain
// Notes:   Write effects are judged two edges after the taking edge
`timescale 1ns/1ps
module plcr_regs_monitor (
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    input wire logic [4:0]             mgmtAddr,
    input wire logic [15:0]            mgmtWrData,
    input wire logic                   mgmtWrEn,
    input wire logic                   mgmtRdEn,
    input wire logic [15:0]            mgmtRdData,
    input wire logic                   mgmtRdValid,
    input wire plcr_pkg::plcr_status_t phyStatus,
    input wire logic                   speedLedOut,
    input wire logic                   linkLedOut,
    input wire logic                   activityCollisionLedOut,
    input wire logic                   autoCrossoverEn,
    input wire logic                   pairSwap,
    input wire logic [4:0]             portAddress
);
    logic wrOvr;
    logic wrMisc;
    logic rdMapped;
    assign wrOvr    = mgmtWrEn && (mgmtAddr == plcr_pkg::ADDR_LED_OVR);
    assign wrMisc   = mgmtWrEn && (mgmtAddr == plcr_pkg::ADDR_MISC);
    assign rdMapped = (mgmtAddr == plcr_pkg::ADDR_LED_OVR) || (mgmtAddr == plcr_pkg::ADDR_MISC);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_read_answer: assert property (mgmtRdEn |-> ##1 mgmtRdValid)
        else $error("read strobe got no answer");
    a_valid_cause: assert property (mgmtRdValid |-> $past(mgmtRdEn))
        else $error("read answer without strobe");
    a_idle_zero: assert property (!mgmtRdValid |-> mgmtRdData == 16'h0000)
        else $error("read data not zero outside answer");
    a_ovr_reserved: assert property (
        mgmtRdEn && mgmtAddr == plcr_pkg::ADDR_LED_OVR |=> mgmtRdData[15:6] == 10'h000)
        else $error("reserved override bits read nonzero");
    a_unmapped_zero: assert property (
        mgmtRdEn && !rdMapped |=> mgmtRdValid && mgmtRdData == 16'h0000)
        else $error("unmapped read not zero");
    a_spd_force: assert property (
        wrOvr && mgmtWrData[5] ##1 !wrOvr |=> speedLedOut == $past(mgmtWrData[2], 2))
        else $error("speed LED not forced");
    a_lnk_force: assert property (
        wrOvr && mgmtWrData[4] ##1 !wrOvr |=> linkLedOut == $past(mgmtWrData[1], 2))
        else $error("link LED not forced");
    a_act_force: assert property (
        wrOvr && mgmtWrData[3] ##1 !wrOvr |=> activityCollisionLedOut == $past(mgmtWrData[0], 2))
        else $error("activity LED not forced");
    a_pair_forced: assert property (
        wrMisc && mgmtWrData[14] ##1 !wrMisc |=> pairSwap)
        else $error("pairs not swapped when forced");
    a_ctrl_copy: assert property (
        wrMisc ##1 !wrMisc |=> portAddress == $past(mgmtWrData[4:0], 2)
            && autoCrossoverEn == $past(mgmtWrData[15], 2))
        else $error("address or crossover copy wrong");
    a_pause_half: assert property (
        mgmtRdEn && mgmtAddr == plcr_pkg::ADDR_MISC && !phyStatus.fullDuplex
            && !$past(phyStatus.fullDuplex) && !$past(phyStatus.fullDuplex, 2)
            |=> mgmtRdData[13:12] == 2'b00)
        else $error("pause reported in half duplex");
endmodule

bind plcr_regs plcr_regs_monitor plcr_regs_monitor_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .mgmtAddr(mgmtAddr), .mgmtWrData(mgmtWrData),
    .mgmtWrEn(mgmtWrEn), .mgmtRdEn(mgmtRdEn), .mgmtRdData(mgmtRdData),
    .mgmtRdValid(mgmtRdValid), .phyStatus(phyStatus), .speedLedOut(speedLedOut),
    .linkLedOut(linkLedOut), .activityCollisionLedOut(activityCollisionLedOut),
    .autoCrossoverEn(autoCrossoverEn), .pairSwap(pairSwap), .portAddress(portAddress)
);

// file: tb/tb.sv
// Purpose: Self-checking bench for the LED override and control registers
// Assumes: Inputs change at the falling edge; self-test stream looped back
// Notes:   Blink half period shortened to four clocks
`timescale 1ns/1ps
module tb;
    logic                   ref_clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic [4:0]             mgmtAddr = 5'h00;
    logic [15:0]            mgmtWrData = 16'h0000;
    logic                   mgmtWrEn = 1'b0;
    logic                   mgmtRdEn = 1'b0;
    logic [15:0]            mgmtRdData;
    logic                   mgmtRdValid;
    plcr_pkg::plcr_status_t st = '0;
    logic [1:0]             locAdv = 2'h0;
    logic [1:0]             parAdv = 2'h0;
    logic                   swapReq = 1'b0;
    logic                   rxBit = 1'b0;
    logic                   speed_led_force_value, link_led_force_value, activity_led_force_value, autoX, pairSwap, txBit;
    logic [4:0]             portAddr;
    logic                   strapAx = 1'b1;
    logic                   strapLo = 1'b1;
    logic [4:0]             strapAddr = 5'h0a;
    int                     failures = 0;
    int                     samplesChecked = 0;
    logic [15:0]            mw [7] = '{16'h002a, 16'h00aa, 16'h006a, 16'h000a, 16'h008a,
                                       16'h004a, 16'h004a};
    logic [6:0]             sv [7] = '{7'h48, 7'h48, 7'h2c, 7'h61, 7'h61, 7'h50, 7'h60};
    logic [2:0]             ex [7] = '{3'h2, 3'h3, 3'h5, 3'h7, 3'h6, 3'h3, 3'h6};
    logic [15:0]            cw [3] = '{16'h400a, 16'h000a, 16'h8015};
    logic [6:0]             ce [3] = '{7'h2a, 7'h0a, 7'h75};

    plcr_regs #(.BLINK_CYCLES(4)) plcr_regs_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .mgmtAddr(mgmtAddr), .mgmtWrData(mgmtWrData),
        .mgmtWrEn(mgmtWrEn), .mgmtRdEn(mgmtRdEn), .mgmtRdData(mgmtRdData),
        .mgmtRdValid(mgmtRdValid), .strapAutoCrossover(strapAx), .strapLedModeLo(strapLo),
        .strapPortAddr(strapAddr), .phyStatus(st), .localAdvPause(locAdv),
        .partnerAdvPause(parAdv), .autoSwapRequest(swapReq), .selftestRxBit(rxBit),
        .speedLedOut(speed_led_force_value), .linkLedOut(link_led_force_value), .activityCollisionLedOut(activity_led_force_value),
        .autoCrossoverEn(autoX), .pairSwap(pairSwap), .portAddress(portAddr),
        .selftestTxBit(txBit)
    );

    always #50 ref_clk = ~ref_clk;
    // Loopback of the self-test stream
    always @(negedge ref_clk) rxBit <= txBit;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
        samplesChecked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        mgmtAddr = a;
        mgmtWrData = d;
        mgmtWrEn = 1'b1;
        @(negedge ref_clk);
        mgmtWrEn = 1'b0;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
        int n;
        @(negedge ref_clk);
        mgmtAddr = a;
        mgmtRdEn = 1'b1;
        @(negedge ref_clk);
        mgmtRdEn = 1'b0;
        n = 0;
        while (mgmtRdValid !== 1'b1 && n < 4) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 4) begin
            chk(16'h0000, 16'h0001, "read timeout");
            give_verdict();
        end else begin
            chk(mgmtRdData, e, $sformatf("read %h", a));
        end
    endtask

    task automatic ledchk(input logic [2:0] e);
        repeat (3) @(negedge ref_clk);
        chk(16'({speed_led_force_value, link_led_force_value, activity_led_force_value}), 16'(e), "leds");
    endtask

    initial begin
        logic       rx;
        logic       tx;
        logic [1:0] seen;
        logic [15:0] w;
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        rdchk(plcr_pkg::ADDR_LED_OVR, 16'h0000);
        rdchk(plcr_pkg::ADDR_MISC, 16'h802a);
        chk(16'({autoX, portAddr}), 16'h002a, "straps");
        $display("test reset done");
        wr(plcr_pkg::ADDR_LED_OVR, 16'hffff);
        rdchk(plcr_pkg::ADDR_LED_OVR, 16'h003f);
        ledchk(3'h7);
        st = 7'h7f;
        for (int i = 0; i < 3; i++) begin
            wr(plcr_pkg::ADDR_LED_OVR, 16'h0020 >> i);
            ledchk(3'h7 & ~(3'h4 >> i));
        end
        st = 7'h00;
        wr(plcr_pkg::ADDR_LED_OVR, 16'h003d);
        ledchk(3'h5);
        rdchk(plcr_pkg::ADDR_LED_OVR, 16'h003d);
        wr(5'h05, 16'hffff);
        rdchk(5'h05, 16'h0000);
        wr(plcr_pkg::ADDR_LED_OVR, 16'h0000);
        $display("test override done");
        for (int i = 0; i < 7; i++) begin
            st = sv[i];
            wr(plcr_pkg::ADDR_MISC, mw[i]);
            ledchk(ex[i]);
        end
        wr(plcr_pkg::ADDR_MISC, 16'h000a);
        st = 7'h5c;
        seen = 2'b00;
        repeat (24) begin
            @(negedge ref_clk);
            seen[link_led_force_value] = 1'b1;
        end
        chk(16'(seen), 16'h0003, "blink");
        $display("test modes done");
        wr(plcr_pkg::ADDR_MISC, 16'h320a);
        rdchk(plcr_pkg::ADDR_MISC, 16'h000a);
        for (int i = 0; i < 32; i++) begin
            {st.fullDuplex, locAdv, parAdv} = 5'(i);
            repeat (3) @(negedge ref_clk);
            rx = st.fullDuplex & (locAdv[0] & parAdv[0]
                 | locAdv[0] & locAdv[1] & ~parAdv[0] & parAdv[1]);
            tx = st.fullDuplex & (locAdv[0] & parAdv[0]
                 | ~locAdv[0] & locAdv[1] & parAdv[0] & parAdv[1]);
            rdchk(plcr_pkg::ADDR_MISC, {2'b00, rx, tx, 12'h00a});
        end
        locAdv = 2'h0;
        $display("test pause done");
        for (int s = 0; s < 2; s++) begin
            w = 16'h010a | (16'(s) << 10);
            // Stop first so a new sequence never starts mid-stream
            wr(plcr_pkg::ADDR_MISC, 16'h000a);
            wr(plcr_pkg::ADDR_MISC, w);
            repeat (40) @(negedge ref_clk);
            rdchk(plcr_pkg::ADDR_MISC, w | 16'h0200);
            wr(plcr_pkg::ADDR_MISC, w | 16'h0800);
            repeat (40) @(negedge ref_clk);
            rdchk(plcr_pkg::ADDR_MISC, w);
            wr(plcr_pkg::ADDR_MISC, w ^ 16'h0100);
            rdchk(plcr_pkg::ADDR_MISC, w ^ 16'h0100);
            wr(plcr_pkg::ADDR_MISC, w);
            repeat (40) @(negedge ref_clk);
            rdchk(plcr_pkg::ADDR_MISC, w | 16'h0200);
        end
        $display("test selftest done");
        for (int i = 0; i < 3; i++) begin
            swapReq = (i != 0);
            wr(plcr_pkg::ADDR_MISC, cw[i]);
            repeat (3) @(negedge ref_clk);
            chk(16'({autoX, pairSwap, portAddr}), 16'(ce[i]), "crossover");
        end
        $display("test crossover done");
        strapAx = 1'b0;
        strapLo = 1'b0;
        strapAddr = 5'h15;
        rst_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        rdchk(plcr_pkg::ADDR_MISC, 16'h0015);
        chk(16'({autoX, portAddr}), 16'h0015, "straps again");
        $display("test strap reset done");
        give_verdict();
    end
endmodule
